//--- hw/fod_object_dict.sv
// object dictionary and network management slave of the node
// assumes requests arrive from framing logic on the same clock
`timescale 1ns/1ns
module fod_object_dict
#(
    // identity words; all values arbitrary
    parameter logic [31:0] DEV_KIND = 32'h0000_0191,
    parameter logic [31:0] VENDOR_CODE = 32'h0000_0a5a,
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0c3c,
    parameter logic [31:0] REVISION_NO = 32'h0000_0001,
    parameter logic [31:0] SERIAL_NO = 32'h0000_0001,
    // command word that asks for a save to flash
    parameter logic [31:0] SAVE_CMD = 32'h0000_0002
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // dictionary request from the service data transfer logic
    input wire logic req_valid,
    input wire fod_pkg::fod_req_s req,
    output logic req_ready_q,
    // dictionary answer
    output logic rsp_valid_q,
    output fod_pkg::fod_rsp_s rsp_q,
    // motor register access
    output logic mot_valid_q,
    output fod_pkg::fod_mot_s mot_q,
    input wire logic mot_ack,
    input wire logic [31:0] mot_rdata,
    // module side
    input wire logic upd_we,
    input wire logic [5:0] upd_num,
    input wire logic [31:0] upd_data,
    output logic cmd_valid_q,
    output logic [31:0] cmd_word_q,
    output logic save_flash_q,
    output logic mod_dirty_q,
    // faults and poll reply flag
    input wire logic [7:0] fault_in,
    output logic error_new_q,
    // network management services
    input wire logic nmt_valid,
    input wire fod_pkg::fod_nmt_s network_management,
    input wire logic iso_active,
    output logic [7:0] nmt_state_q,
    output logic reply_valid_q,
    output logic [1:0] reply_kind_q,
    output logic [31:0] reply_word_q,
    output logic svc_refused_q
);
    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    typedef enum {S_IDLE, S_MOTOR} fod_state_e;
    fod_state_e st_q; // request sequencer state
    logic [7:0] fault_q; // fault summary
    logic [7:0] last_new_q; // bits that rose last
    logic [31:0] mod_rdata; // module window read data
    logic take; // request accepted this cycle
    logic dec_abort; // decoded access refused
    logic [31:0] dec_data; // decoded read data or abort code
    logic dec_mod_we; // decoded module window write
    logic [5:0] dec_num; // module register number
    logic dec_mot; // decoded motor access
    logic mod_we; // module write strobe

    assign take = req_valid && req_ready_q;
    assign mod_we = take && dec_mod_we;

    // ------------------------------------------------------------
    // leaf instances
    // ------------------------------------------------------------
    // fault summary and error-new toggle
    fod_fault_track u_fault
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .fault_in(fault_in),
        .fault_q(fault_q),
        .error_new_q(error_new_q),
        .last_new_q(last_new_q)
    );
    // module registers, saved on command
    fod_modreg_file u_modreg
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .dict_we(mod_we),
        .dict_num(dec_num),
        .dict_data(req.wdata),
        .upd_we(upd_we),
        .upd_num(upd_num),
        .upd_data(upd_data),
        .rd_num(req.sub[5:0]),
        .rd_data(mod_rdata),
        .save_done(save_flash_q),
        .dirty_q(mod_dirty_q)
    );

    // ------------------------------------------------------------
    // object decode
    // ------------------------------------------------------------
    // index then subindex, refused accesses turn into aborts
    always_comb
    begin
        dec_abort = 1'b0;
        dec_data = 32'h0000_0000;
        dec_mod_we = 1'b0;
        dec_num = req.sub[5:0];
        dec_mot = 1'b0;
        // device kind word
        if (req.index == fod_pkg::IDX_DEV_KIND && req.sub == fod_pkg::SUB_COUNT)
        begin
            dec_abort = req.write;
            dec_data = req.write ? fod_pkg::ABORT_READ_ONLY : DEV_KIND;
        end
        // fault summary byte, zero extended
        else if (req.index == fod_pkg::IDX_FAULT && req.sub == fod_pkg::SUB_COUNT)
        begin
            dec_abort = req.write;
            dec_data = req.write ? fod_pkg::ABORT_READ_ONLY : {24'h000000, fault_q};
        end
        // identity record
        else if (req.index == fod_pkg::IDX_IDENT && req.sub <= fod_pkg::IDENT_COUNT)
        begin
            if (req.write)
            begin
                dec_abort = 1'b1;
                dec_data = fod_pkg::ABORT_READ_ONLY;
            end
            else if (req.sub == fod_pkg::SUB_COUNT)
                dec_data = {24'h000000, fod_pkg::IDENT_COUNT};
            else if (req.sub == fod_pkg::SUB_VENDOR)
                dec_data = VENDOR_CODE;
            else if (req.sub == fod_pkg::SUB_PRODUCT)
                dec_data = PRODUCT_CODE;
            else if (req.sub == fod_pkg::SUB_REVISION)
                dec_data = REVISION_NO;
            else
                dec_data = SERIAL_NO;
        end
        // module command, write only
        else if (req.index == fod_pkg::IDX_MOD_CMD && req.sub == fod_pkg::SUB_COUNT)
        begin
            dec_num = fod_pkg::MOD_CMD_NUM;
            dec_mod_we = req.write;
            dec_abort = !req.write;
            dec_data = req.write ? 32'h0000_0000 : fod_pkg::ABORT_WRITE_ONLY;
        end
        // module window count
        else if (req.index == fod_pkg::IDX_MOD_WIN && req.sub == fod_pkg::SUB_COUNT)
        begin
            dec_abort = req.write;
            dec_data = req.write ? fod_pkg::ABORT_READ_ONLY : {24'h000000, fod_pkg::MOD_COUNT};
        end
        // module window words
        else if (req.index == fod_pkg::IDX_MOD_WIN && req.sub <= fod_pkg::MOD_COUNT)
        begin
            if (!req.write)
                dec_data = mod_rdata;
            else if (fod_pkg::mod_writable(req.sub[5:0]))
                dec_mod_we = 1'b1;
            else
            begin
                dec_abort = 1'b1;
                dec_data = fod_pkg::ABORT_READ_ONLY;
            end
        end
        // motor window count
        else if (req.index == fod_pkg::IDX_MOT_WIN && req.sub == fod_pkg::SUB_COUNT)
        begin
            dec_abort = req.write;
            dec_data = req.write ? fod_pkg::ABORT_READ_ONLY : {24'h000000, fod_pkg::MOT_COUNT};
        end
        // motor window words go out to the motor
        else if (req.index == fod_pkg::IDX_MOT_WIN && req.sub <= fod_pkg::MOT_COUNT)
            dec_mot = 1'b1;
        // anything else is absent
        else
        begin
            dec_abort = 1'b1;
            dec_data = fod_pkg::ABORT_NO_OBJECT;
        end
    end

    // ------------------------------------------------------------
    // request sequencer
    // ------------------------------------------------------------
    // local objects answer next cycle; motor words wait for ack
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_q <= S_IDLE;
            req_ready_q <= 1'b1;
        end
        else
        begin
            case (st_q)
                S_IDLE:
                begin
                    // hold off new requests during a motor access
                    if (take && dec_mot)
                    begin
                        st_q <= S_MOTOR;
                        req_ready_q <= 1'b0;
                    end
                end
                S_MOTOR:
                begin
                    // reopen once the motor answers
                    if (mot_ack)
                    begin
                        st_q <= S_IDLE;
                        req_ready_q <= 1'b1;
                    end
                end
                default:
                begin
                    st_q <= S_IDLE;
                    req_ready_q <= 1'b1;
                end
            endcase
        end
    end

    // motor request stands until acknowledged
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            mot_valid_q <= 1'b0;
            mot_q <= '0;
        end
        else if (take && dec_mot)
        begin
            mot_valid_q <= 1'b1;
            mot_q.write <= req.write;
            mot_q.num <= req.sub;
            mot_q.wdata <= req.wdata;
        end
        else if (mot_ack)
            mot_valid_q <= 1'b0;
    end

    // answer pulse for local objects and finished motor accesses
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end
        else if (st_q == S_MOTOR && mot_ack)
        begin
            rsp_valid_q <= 1'b1;
            rsp_q.abort <= 1'b0;
            rsp_q.data <= mot_q.write ? 32'h0000_0000 : mot_rdata;
        end
        else if (take && !dec_mot)
        begin
            rsp_valid_q <= 1'b1;
            rsp_q.abort <= dec_abort;
            rsp_q.data <= dec_data;
        end
        else
            rsp_valid_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // module command path
    // ------------------------------------------------------------
    // a write to word 15 by either object issues the command
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cmd_valid_q <= 1'b0;
            cmd_word_q <= 32'h0000_0000;
            save_flash_q <= 1'b0;
        end
        else if (mod_we && dec_num == fod_pkg::MOD_CMD_NUM)
        begin
            cmd_valid_q <= 1'b1;
            cmd_word_q <= req.wdata;
            save_flash_q <= (req.wdata == SAVE_CMD);
        end
        else
        begin
            cmd_valid_q <= 1'b0;
            save_flash_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // network management slave
    // ------------------------------------------------------------
    // node state follows the managing node's state commands only
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            nmt_state_q <= 8'h00;
        else if (nmt_valid && network_management.cat == fod_pkg::CAT_STATE_CMD)
            nmt_state_q <= network_management.state;
    end

    // response services; categories other than response and state command are refused
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reply_valid_q <= 1'b0;
            reply_kind_q <= fod_pkg::KIND_STATE;
            reply_word_q <= 32'h0000_0000;
            svc_refused_q <= 1'b0;
        end
        else
        begin
            reply_valid_q <= 1'b0;
            svc_refused_q <= 1'b0;
            if (nmt_valid && network_management.cat == fod_pkg::CAT_RESPONSE)
            begin
                reply_kind_q <= network_management.kind;
                if (network_management.kind == fod_pkg::KIND_STATE)
                begin
                    reply_valid_q <= 1'b1;
                    reply_word_q <= {24'h000000, nmt_state_q};
                end
                else if (network_management.kind == fod_pkg::KIND_IDENT)
                begin
                    reply_valid_q <= 1'b1;
                    reply_word_q <= VENDOR_CODE;
                end
                else if (network_management.kind == fod_pkg::KIND_STATUS && !iso_active)
                begin
                    reply_valid_q <= 1'b1;
                    reply_word_q <= {fod_pkg::STATUS_PAD, last_new_q, fault_q};
                end
                else
                    svc_refused_q <= 1'b1;
            end
            else if (nmt_valid && network_management.cat != fod_pkg::CAT_STATE_CMD)
                svc_refused_q <= 1'b1;
        end
    end
endmodule // fod_object_dict

//--- hw/fod_pkg.sv
// package for the fieldbus object dictionary block
// assumes one clock domain; all users write fod_pkg::name
package fod_pkg;
    // ------------------------------------------------------------
    // object indexes and subindex figures
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_DEV_KIND = 16'h1000;
    localparam logic [15:0] IDX_FAULT = 16'h1001;
    localparam logic [15:0] IDX_IDENT = 16'h1018;
    localparam logic [15:0] IDX_MOD_CMD = 16'h2010;
    localparam logic [15:0] IDX_MOD_WIN = 16'h2011;
    localparam logic [15:0] IDX_MOT_WIN = 16'h2012;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_VENDOR = 8'h01;
    localparam logic [7:0] SUB_PRODUCT = 8'h02;
    localparam logic [7:0] SUB_REVISION = 8'h03;
    localparam logic [7:0] SUB_SERIAL = 8'h04;
    localparam logic [7:0] IDENT_COUNT = 8'h04;
    localparam logic [7:0] MOD_COUNT = 8'h3f;
    localparam logic [7:0] MOT_COUNT = 8'hfe;
    localparam logic [5:0] MOD_CMD_NUM = 6'h0f;
    localparam logic [5:0] MOD_RW_ONE = 6'h03;
    localparam logic [5:0] MOD_RW_LO = 6'h06;
    localparam logic [5:0] MOD_RW_HI = 6'h1f;
    localparam logic [31:0] MOD_RST = 32'h0000_0000;
    // ------------------------------------------------------------
    // fault summary layout; bit 6 is reserved and reads zero
    // ------------------------------------------------------------
    localparam int FB_GENERIC = 0;
    localparam logic [7:0] FAULT_MASK = 8'hbe;
    // ------------------------------------------------------------
    // abort codes returned on a refused access
    // ------------------------------------------------------------
    localparam logic [31:0] ABORT_READ_ONLY = 32'h0000_0001;
    localparam logic [31:0] ABORT_WRITE_ONLY = 32'h0000_0002;
    localparam logic [31:0] ABORT_NO_OBJECT = 32'h0000_0003;
    // ------------------------------------------------------------
    // network management service categories and reply kinds
    // ------------------------------------------------------------
    localparam logic [2:0] CAT_STATE_CMD = 3'h0;
    localparam logic [2:0] CAT_RESPONSE = 3'h2;
    localparam logic [1:0] KIND_STATE = 2'h0;
    localparam logic [1:0] KIND_IDENT = 2'h1;
    localparam logic [1:0] KIND_STATUS = 2'h2;
    localparam logic [15:0] STATUS_PAD = 16'h0000;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } fod_req_s;
    typedef struct packed {
        logic abort;
        logic [31:0] data;
    } fod_rsp_s;
    typedef struct packed {
        logic write;
        logic [7:0] num;
        logic [31:0] wdata;
    } fod_mot_s;
    typedef struct packed {
        logic [2:0] cat;
        logic [1:0] kind;
        logic [7:0] state;
    } fod_nmt_s;
    // module window subindexes that take writes
    function automatic logic mod_writable(input logic [5:0] num);
        return (num == MOD_RW_ONE) || ((num >= MOD_RW_LO) && (num <= MOD_RW_HI));
    endfunction
endpackage

//--- hw/fod_fault_track.sv
// fault summary register and error-new toggle
// assumes fault conditions come from logic on the same clock
`timescale 1ns/1ns
module fod_fault_track
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // live fault conditions, one per summary bit
    input wire logic [7:0] fault_in,
    // summary, toggle flag and bits that rose last
    output logic [7:0] fault_q,
    output logic error_new_q,
    output logic [7:0] last_new_q
);
    // ------------------------------------------------------------
    // new-fault detection
    // ------------------------------------------------------------
    logic [7:0] fault_d; // masked summary with generic bit
    logic [7:0] rise; // bits that were clear and are now set
    always_comb
    begin
        fault_d = fault_in & fod_pkg::FAULT_MASK;
        fault_d[fod_pkg::FB_GENERIC] = |fault_d;
        rise = fault_d & ~fault_q;
    end
    // summary register, read only from the dictionary side
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            fault_q <= 8'h00;
        else
            fault_q <= fault_d;
    end
    // invert the flag once in each cycle in which any bit rises, never drive a level
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            error_new_q <= 1'b0;
            last_new_q <= 8'h00;
        end
        else if (|rise)
        begin
            error_new_q <= ~error_new_q;
            last_new_q <= rise;
        end
    end
endmodule // fod_fault_track

//--- hw/fod_modreg_file.sv
// module register file behind the module window, 63 words
// assumes both write ports are on the same clock; module side wins
`timescale 1ns/1ns
module fod_modreg_file
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // dictionary write port
    input wire logic dict_we,
    input wire logic [5:0] dict_num,
    input wire logic [31:0] dict_data,
    // module-side update port for status words
    input wire logic upd_we,
    input wire logic [5:0] upd_num,
    input wire logic [31:0] upd_data,
    // read port and save handshake
    input wire logic [5:0] rd_num,
    output logic [31:0] rd_data,
    input wire logic save_done,
    output logic dirty_q
);
    // ------------------------------------------------------------
    // storage, index 0 unused
    // ------------------------------------------------------------
    logic [31:0] mem_q [0:63];
    // word writes; only writable numbers accepted from the dictionary
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 64; i++)
                mem_q[i] <= fod_pkg::MOD_RST;
        end
        else if (upd_we)
            mem_q[upd_num] <= upd_data;
        else if (dict_we && (fod_pkg::mod_writable(dict_num) || dict_num == fod_pkg::MOD_CMD_NUM))
            mem_q[dict_num] <= dict_data;
    end
    // changes stay volatile until saved; a new change beats the save
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            dirty_q <= 1'b0;
        else if (dict_we && dict_num != fod_pkg::MOD_CMD_NUM)
            dirty_q <= 1'b1;
        else if (save_done)
            dirty_q <= 1'b0;
    end
    // read mux
    assign rd_data = mem_q[rd_num];
endmodule // fod_modreg_file

//--- dv/fod_object_dict_chk.sv
// port checker for the object dictionary
// bound to every fod_object_dict instance below
`timescale 1ns/1ns
module fod_object_dict_chk
#(
    parameter logic [31:0] SAVE_CMD = 32'h0000_0002
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire fod_pkg::fod_req_s req,
    input wire logic req_ready_q,
    input wire logic rsp_valid_q,
    input wire fod_pkg::fod_rsp_s rsp_q,
    input wire logic mot_valid_q,
    input wire fod_pkg::fod_mot_s mot_q,
    input wire logic mot_ack,
    input wire logic cmd_valid_q,
    input wire logic [31:0] cmd_word_q,
    input wire logic save_flash_q,
    input wire logic nmt_valid,
    input wire fod_pkg::fod_nmt_s network_management,
    input wire logic [7:0] nmt_state_q,
    input wire logic reply_valid_q,
    input wire logic svc_refused_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a request is taken on this edge
    wire take = req_valid && req_ready_q;
    chk_local_answer: assert property (take && req.index != 16'h2012 |=> rsp_valid_q)
        else $error("local request not answered");
    chk_ro_refused: assert property (take && req.write && req.index == 16'h1000
        |=> rsp_q.abort && rsp_q.data == 32'h1) else $error("read-only write taken");
    chk_mod_count: assert property (take && !req.write && req.index == 16'h2011
        && req.sub == 8'h00 |=> rsp_q.data == 32'h3f) else $error("bad module count");
    chk_cmd_word: assert property (take && req.write && req.index == 16'h2010
        |=> cmd_valid_q && cmd_word_q == $past(req.wdata)) else $error("command lost");
    chk_save_pulse: assert property (cmd_valid_q |-> save_flash_q == (cmd_word_q == SAVE_CMD))
        else $error("save pulse wrong");
    chk_mot_hold: assert property (mot_valid_q && !mot_ack
        |=> mot_valid_q && $stable(mot_q) && !req_ready_q) else $error("motor request dropped");
    chk_state_set: assert property (nmt_valid && network_management.cat == 3'h0
        |=> nmt_state_q == $past(network_management.state) && !reply_valid_q) else $error("state not set");
    chk_bad_cat: assert property (nmt_valid && network_management.cat != 3'h0 && network_management.cat != 3'h2
        |=> svc_refused_q && !reply_valid_q) else $error("bad service served");
endmodule // fod_object_dict_chk
bind fod_object_dict fod_object_dict_chk #(.SAVE_CMD(SAVE_CMD)) fod_object_dict_chk_i (
    .clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q),
    .mot_valid_q(mot_valid_q), .mot_q(mot_q), .mot_ack(mot_ack), .cmd_valid_q(cmd_valid_q),
    .cmd_word_q(cmd_word_q), .save_flash_q(save_flash_q), .nmt_valid(nmt_valid), .network_management(network_management),
    .nmt_state_q(nmt_state_q), .reply_valid_q(reply_valid_q), .svc_refused_q(svc_refused_q));

//--- dv/fod_motor_model.sv
// motor side model: 256 words behind the motor window
// answers after one or three cycles; data wobbles between answers
`timescale 1ns/1ns
module fod_motor_model
(
    input wire logic clock,
    input wire logic slow,
    input wire logic mot_valid_q,
    input wire fod_pkg::fod_mot_s mot_q,
    output logic mot_ack = 1'b0,
    output logic [31:0] mot_rdata = 32'h0
);
    logic [31:0] mem [256] = '{default: 32'h0};
    int wait_n = 0;
    always @(posedge clock)
    begin
        mot_ack <= 1'b0;
        mot_rdata <= ~mot_rdata;
        if (mot_valid_q && !mot_ack)
        begin
            if (wait_n < (slow ? 2 : 0))
                wait_n <= wait_n + 1;
            else
            begin
                wait_n <= 0;
                mot_ack <= 1'b1;
                if (mot_q.write)
                    mem[mot_q.num] <= mot_q.wdata;
                else
                    mot_rdata <= mem[mot_q.num];
            end
        end
    end
endmodule // fod_motor_model

//--- dv/test_fod_object_dict.sv
// bench for the object dictionary with a motor model
// assumes the checker binds itself
`timescale 1ns/1ns
module test_fod_object_dict;
    logic clock = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, upd_we = 1'b0, nmt_valid = 1'b0;
    logic iso_active = 1'b0, slow = 1'b0, rab, sv, cv, w;
    fod_pkg::fod_req_s req = '0;
    fod_pkg::fod_nmt_s network_management = '0;
    fod_pkg::fod_rsp_s rsp_q;
    fod_pkg::fod_mot_s mot_q;
    logic [5:0] upd_num = 6'h01;
    logic [31:0] upd_data = 32'h0, seed = 32'h34ee, mot_rdata, cmd_word_q, reply_word_q, rdat;
    logic [7:0] fault_in = 8'h00, nmt_state_q, sb;
    logic [1:0] reply_kind_q;
    logic req_ready_q, rsp_valid_q, mot_valid_q, mot_ack, cmd_valid_q, save_flash_q;
    logic mod_dirty_q, error_new_q, reply_valid_q, svc_refused_q;
    logic [31:0] mo [64] = '{default: 32'h0};
    logic [31:0] mt [256] = '{default: 32'h0};
    logic [56:0] tab [10] = '{{1'b0, 16'h1000, 8'h00, 32'h191}, {1'b0, 16'h1018, 8'h01, 32'ha5a},
        {1'b0, 16'h1018, 8'h02, 32'hc3c}, {1'b0, 16'h1018, 8'h00, 32'h4},
        {1'b0, 16'h1018, 8'h03, 32'h1}, {1'b0, 16'h1018, 8'h04, 32'h1},
        {1'b0, 16'h2011, 8'h00, 32'h3f}, {1'b0, 16'h2012, 8'h00, 32'hfe},
        {1'b1, 16'h2010, 8'h00, 32'h2}, {1'b1, 16'h2012, 8'hff, 32'h3}};
    logic [16:0] ft [3] = '{{8'h02, 8'h03, 1'b1}, {8'h42, 8'h03, 1'b1}, {8'h06, 8'h07, 1'b0}};
    int n_errors = 0;
    int compares = 0;
    always #5 clock = ~clock;
    // every design port has a bench signal of the same name
    fod_object_dict fod_object_dict_i (.*);
    fod_motor_model fod_motor_model_i (.clock(clock), .slow(slow), .mot_valid_q(mot_valid_q),
        .mot_q(mot_q), .mot_ack(mot_ack), .mot_rdata(mot_rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic finish_test;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tk;
        @(posedge clock);
        #1;
    endtask
    // one dictionary transfer, held until taken, answer captured
    task automatic acc(input logic wr, input logic [15:0] ix, input logic [7:0] s,
        input logic [31:0] d);
        int n;
        logic t;
        n = 0;
        t = 1'b0;
        req = '{wr, ix, s, d};
        req_valid = 1'b1;
        while (!t && n < 50)
        begin
            t = req_ready_q;
            tk();
            n++;
        end
        req_valid = 1'b0;
        while (rsp_valid_q !== 1'b1 && n < 50)
        begin
            tk();
            n++;
        end
        {rab, rdat, sv, cv} = {rsp_q, save_flash_q, cmd_valid_q};
        if (n >= 50)
        begin
            n_errors++;
            finish_test();
        end
        tk();
    endtask
    // one management service; reply is visible on return
    task automatic svc(input logic [2:0] c, input logic [1:0] k, input logic [7:0] s);
        tk();
        network_management = '{c, k, s};
        nmt_valid = 1'b1;
        tk();
        nmt_valid = 1'b0;
    endtask
    initial
    begin
        repeat (8) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        for (int r = 0; r < 2; r++)
        begin
            for (int i = 0; i < 10; i++)
            begin
                acc(1'b0, tab[i][55:40], tab[i][39:32], 32'h0);
                chk("object", tab[i][31:0], rdat);
                chk("abort", {31'h0, tab[i][56]}, {31'h0, rab});
            end
            for (int i = 0; i < 3; i++)
            begin
                seed = lfsr(seed);
                acc(1'b1, tab[i][55:40], tab[i][39:32], seed);
                chk("ro write", 32'h1, {rdat[31:1], rab});
            end
        end
        for (int i = 0; i < 40; i++)
        begin
            seed = lfsr(seed);
            sb = {2'b00, seed[5:0]};
            w = sb == 8'h03 || (sb >= 8'h06 && sb <= 8'h1f);
            acc(1'b1, 16'h2011, sb, seed);
            chk("mod abort", {31'h0, !w}, {31'h0, rab});
            if (w)
                mo[sb] = seed;
            acc(1'b0, 16'h2011, sb, 32'h0);
            chk("mod word", sb == 8'h00 ? 32'h3f : mo[sb], rdat);
        end
        acc(1'b1, 16'h2010, 8'h00, seed);
        chk("cmd", {seed[31:1], 1'b1}, {cmd_word_q[31:1], cv});
        acc(1'b0, 16'h2011, 8'h0f, 32'h0);
        chk("cmd mirror", seed, rdat);
        acc(1'b1, 16'h2011, 8'h06, seed);
        chk("dirty set", 32'h1, {31'h0, mod_dirty_q});
        acc(1'b1, 16'h2010, 8'h00, 32'h2);
        chk("save", 32'h2, {30'h0, sv, mod_dirty_q});
        upd_data = seed;
        upd_we = 1'b1;
        tk();
        upd_we = 1'b0;
        acc(1'b0, 16'h2011, 8'h01, 32'h0);
        chk("status word", seed, rdat);
        for (int i = 0; i < 30; i++)
        begin
            seed = lfsr(seed);
            sb = (seed[7:0] == 8'h00 || seed[7:0] == 8'hff) ? 8'h01 : seed[7:0];
            slow = seed[8];
            acc(seed[9], 16'h2012, sb, seed);
            chk("motor", seed[9] ? 32'h0 : mt[sb], rdat);
            if (seed[9])
                mt[sb] = seed;
        end
        for (int i = 0; i < 3; i++)
        begin
            fault_in = ft[i][16:9];
            tk();
            acc(1'b0, 16'h1001, 8'h00, 32'h0);
            chk("fault", {23'h0, ft[i][8:0]}, {23'h0, rdat[7:0], error_new_q});
        end
        svc(3'h2, 2'h2, 8'h00);
        chk("status", 32'h60407, {reply_valid_q, reply_kind_q, reply_word_q[15:0]});
        iso_active = 1'b1;
        svc(3'h2, 2'h2, 8'h00);
        chk("iso refuse", 32'h1, {31'h0, svc_refused_q});
        iso_active = 1'b0;
        svc(3'h0, 2'h0, seed[7:0]);
        chk("state", {24'h0, seed[7:0]}, {24'h0, nmt_state_q});
        svc(3'h2, 2'h0, 8'h00);
        chk("state reply", {24'h0, seed[7:0]}, reply_word_q);
        svc(3'h2, 2'h1, 8'h00);
        chk("ident", 32'ha5a, reply_word_q);
        for (int c = 0; c < 8; c++)
        begin
            svc(3'(c), 2'h0, seed[15:8]);
            chk("refuse", {31'h0, c != 0 && c != 2}, {31'h0, svc_refused_q});
        end
        finish_test();
    end
endmodule // test_fod_object_dict
